// [prox_irq_defines.vh]
// Constants for the proximity mode and threshold interrupt block.
// Assumes an 8-bit register view as seen by the host bus bridge.
`ifndef PROX_IRQ_DEFINES_VH
`define PROX_IRQ_DEFINES_VH
// =========================================================
// Register offsets
`define OFS_PROX_CTRL 8'h81
`define OFS_INT_CFG 8'hA7
`define OFS_PERSIST 8'hA8
`define OFS_UPPER_LSB 8'hA9
`define OFS_UPPER_MSB 8'hAA
`define OFS_LOWER_LSB 8'hAB
`define OFS_LOWER_MSB 8'hAC
// =========================================================
// Field positions
`define CTRL_ACTIVE_BIT 1
`define CTRL_LOGIC_BIT 2
`define CTRL_SWRST_BIT 0
`define CFG_LOGIC_BIT 1
`define CFG_POL_BIT 3
`define CFG_MODE_HI 2
`define CFG_MODE_LO 1
`define PERSIST_HI 7
`define PERSIST_LO 4
// =========================================================
// Reset values and encodings
`define RST_INT_CFG 8'h40
`define RST_PERSIST 8'h00
`define RST_UPPER 16'hFFFF
`define RST_LOWER 16'h0000
`define MODE_OFF 2'h0
`define MODE_PROX 2'h1
// =========================================================
// Timing counts
`define MEAS_TIME_NS 1000
`define CLK_NS 8
`define MEAS_CYCLES ((`MEAS_TIME_NS + `CLK_NS - 1) / `CLK_NS)
`define START_CYCLES 16
`endif

// [prox_persist_filter.v]
// Consecutive out-of-range filter for fresh measurement results.
// Assumes i_fresh pulses once per completed measurement, same clock.
`timescale 1ns/1ps
`default_nettype none
module prox_persist_filter #(
    parameter CW = 4
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_b,
    input wire i_clr,
    // Measurement events
    input wire i_fresh,
    input wire i_out_range,
    input wire [CW-1:0] i_need,
    // Qualified event
    output reg o_fire
);
    reg [CW-1:0] cnt_q;
    // =====================================================
    // Run counter
    // Count of zero fires on every out-of-range result
    always @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            cnt_q <= {CW{1'b0}};
            o_fire <= 1'b0;
        end
        else if (i_clr)
        begin
            cnt_q <= {CW{1'b0}};
            o_fire <= 1'b0;
        end
        else
        begin
            o_fire <= 1'b0;
            if (i_fresh)
            begin
                if (!i_out_range)
                    cnt_q <= {CW{1'b0}};
                // A saturated count must not wrap back below the need
                else if (cnt_q == {CW{1'b1}} || cnt_q + 1'b1 >= i_need ||
                         i_need == {CW{1'b0}})
                begin
                    // Saturate so a long run keeps firing
                    o_fire <= 1'b1;
                    if (cnt_q != {CW{1'b1}})
                        cnt_q <= cnt_q + 1'b1;
                end
                else
                    cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule // prox_persist_filter
`default_nettype wire

// [prox_irq.v]
// Mode control and threshold interrupt of a proximity sensor.
// Assumes a bus bridge on i_clk delivers register writes as byte strobes.
// Function
// RULE1 - Come up in stand-by, no measuring until active mode chosen.
// RULE2 - Register writes are accepted in stand-by as well.
// RULE3 - Software reset repeats the power-on start-up sequence.
// RULE4 - Each active measurement completes after a fixed cycle count.
// RULE5 - Flag data above upper or below lower threshold.
// RULE6 - Compare only freshly completed measurements.
// RULE7 - Interrupt shown on pin and in status register.
// RULE8 - Register control enables or disables pin drive.
// RULE9 - Register selects low or high active pin level.
// RULE10 - Window and logic interrupt types offered.
// RULE11 - Logic type needs control bit 2 and config bit 1.
// RULE12 - Window type is default, no transition reports.
// RULE13 - Logic type reports far-to-near above, near-to-far below.
// RULE14 - Interrupt after programmable count of consecutive out-of-range.
// RULE15 - Polarity bit 3: 0 active low, 1 active high.
// RULE16 - Mode 00 pin released, 01 measurements trigger.
// RULE17 - Upper threshold resets all ones, lower all zeros.
`timescale 1ns/1ps
`default_nettype none
`include "prox_irq_defines.vh"
module prox_irq #(
    parameter DW = 16,
    parameter MEAS_CYC = `MEAS_CYCLES
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_b,
    // Register write port
    input wire i_wr,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_int_clr,
    // Analog front end result
    input wire [DW-1:0] i_meas_data,
    // Status
    output reg o_active,
    output reg o_ready,
    output reg o_meas_start,
    output reg [DW-1:0] o_proximity_measurement,
    output reg o_meas_valid,
    output reg o_int_status,
    output reg o_far_to_near_report,
    output reg o_near_to_far_report,
    output reg [7:0] o_proximity_control_register,
    output reg [7:0] o_int_cfg,
    output reg [7:0] o_persist,
    output reg [DW-1:0] o_upper_limit_value,
    output reg [DW-1:0] o_lower_limit_value,
    // Interrupt pin, open drain style
    output wire o_int_pin,
    output wire o_int_oe_b
);
    localparam ST_START = 2'h0;
    localparam ST_IDLE = 2'h1;
    localparam ST_MEAS = 2'h2;
    reg [1:0] state_q;
    reg [15:0] cnt_q;
    reg swrst_q;
    reg near_q;
    wire fire;
    wire above;
    wire below;
    wire logic_type;
    wire [1:0] int_mode;
    wire polarity;
    // =====================================================
    // Decode of configuration
    // RULE10 RULE11 logic type select
    assign logic_type = o_proximity_control_register[`CTRL_LOGIC_BIT] &
                        o_int_cfg[`CFG_LOGIC_BIT];
    assign int_mode = o_int_cfg[`CFG_MODE_HI:`CFG_MODE_LO];
    assign polarity = o_int_cfg[`CFG_POL_BIT];
    // RULE5 threshold compare on captured data
    assign above = o_proximity_measurement > o_upper_limit_value;
    assign below = o_proximity_measurement < o_lower_limit_value;
    // =====================================================
    // Register writes, accepted in every state
    // Soft reset rebuilds the power-on state one cycle later, except the captured measurement
    always @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_proximity_control_register <= 8'h00;
            o_int_cfg <= `RST_INT_CFG;
            o_persist <= `RST_PERSIST;
            // RULE17 threshold defaults
            o_upper_limit_value <= `RST_UPPER;
            o_lower_limit_value <= `RST_LOWER;
            swrst_q <= 1'b0;
        end
        else if (swrst_q)
        begin
            // RULE3 same defaults as power-on
            o_proximity_control_register <= 8'h00;
            o_int_cfg <= `RST_INT_CFG;
            o_persist <= `RST_PERSIST;
            o_upper_limit_value <= `RST_UPPER;
            o_lower_limit_value <= `RST_LOWER;
            swrst_q <= 1'b0;
        end
        // RULE2 writes taken in stand-by too
        else if (i_wr)
        begin
            case (i_addr)
                `OFS_PROX_CTRL:
                begin
                    o_proximity_control_register <= i_wdata;
                    swrst_q <= i_wdata[`CTRL_SWRST_BIT];
                end
                `OFS_INT_CFG: o_int_cfg <= i_wdata;
                `OFS_PERSIST: o_persist <= i_wdata;
                `OFS_UPPER_LSB: o_upper_limit_value[7:0] <= i_wdata;
                `OFS_UPPER_MSB: o_upper_limit_value[15:8] <= i_wdata;
                `OFS_LOWER_LSB: o_lower_limit_value[7:0] <= i_wdata;
                `OFS_LOWER_MSB: o_lower_limit_value[15:8] <= i_wdata;
                default: swrst_q <= 1'b0;
            endcase
        end
    end
    // =====================================================
    // Mode and measurement sequencer
    always @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            // RULE1 start-up then stand-by
            state_q <= ST_START;
            cnt_q <= 16'h0000;
            o_meas_start <= 1'b0;
            o_meas_valid <= 1'b0;
            o_proximity_measurement <= {DW{1'b0}};
        end
        else
        begin
            o_meas_start <= 1'b0;
            o_meas_valid <= 1'b0;
            if (swrst_q)
            begin
                // RULE3 rerun start-up
                state_q <= ST_START;
                cnt_q <= 16'h0000;
            end
            else
            begin
                case (state_q)
                    ST_START:
                    begin
                        cnt_q <= cnt_q + 16'h0001;
                        if (cnt_q == `START_CYCLES - 1)
                        begin
                            state_q <= ST_IDLE;
                            cnt_q <= 16'h0000;
                        end
                    end
                    ST_IDLE:
                        // RULE1 measure only in active mode
                        if (o_proximity_control_register[`CTRL_ACTIVE_BIT])
                        begin
                            state_q <= ST_MEAS;
                            cnt_q <= 16'h0000;
                            o_meas_start <= 1'b1;
                        end
                    ST_MEAS:
                    begin
                        cnt_q <= cnt_q + 16'h0001;
                        // RULE4 fixed conversion time
                        if (cnt_q == MEAS_CYC[15:0] - 16'h0001)
                        begin
                            state_q <= ST_IDLE;
                            o_proximity_measurement <= i_meas_data;
                            // RULE6 one pulse per new result
                            o_meas_valid <= 1'b1;
                        end
                    end
                    default: state_q <= ST_START;
                endcase
            end
        end
    end
    // =====================================================
    // Consecutive count filter
    // RULE14 persistence on fresh results only
    prox_persist_filter #(
        .CW(4)
    ) u_persist (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_clr(swrst_q),
        .i_fresh(o_meas_valid),
        .i_out_range(logic_type ? (near_q ? below : above) : (above | below)),
        .i_need(o_persist[`PERSIST_HI:`PERSIST_LO]),
        .o_fire(fire)
    );
    // =====================================================
    // Interrupt status and transition reports
    // Set wins over a clear in the same cycle
    always @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_int_status <= 1'b0;
            o_far_to_near_report <= 1'b0;
            o_near_to_far_report <= 1'b0;
            near_q <= 1'b0;
        end
        else if (swrst_q)
        begin
            o_int_status <= 1'b0;
            o_far_to_near_report <= 1'b0;
            o_near_to_far_report <= 1'b0;
            near_q <= 1'b0;
        end
        // RULE16 only mode 01 lets results trigger
        else if (fire && int_mode == `MODE_PROX)
        begin
            // RULE7 status bit mirrors the pin
            o_int_status <= 1'b1;
            // RULE13 hysteresis between near and far
            if (logic_type)
            begin
                near_q <= ~near_q;
                o_far_to_near_report <= ~near_q;
                o_near_to_far_report <= near_q;
            end
            else
            begin
                // RULE12 window type has no reports
                o_far_to_near_report <= 1'b0;
                o_near_to_far_report <= 1'b0;
            end
        end
        else
        begin
            if (i_int_clr)
                o_int_status <= 1'b0;
            // RULE12 reports drop once window type is chosen
            if (i_int_clr || !logic_type)
            begin
                o_far_to_near_report <= 1'b0;
                o_near_to_far_report <= 1'b0;
            end
        end
    end
    // =====================================================
    // Pin drive and mode flags
    // RULE8 pin released when mode is 00
    assign o_int_oe_b = (int_mode == `MODE_OFF);
    // RULE9 RULE15 polarity select
    assign o_int_pin = polarity ? o_int_status : ~o_int_status;
    // Registered status flags for the host
    always @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_active <= 1'b0;
            o_ready <= 1'b0;
        end
        else
        begin
            o_active <= (state_q == ST_MEAS);
            o_ready <= (state_q != ST_START);
        end
    end
endmodule // prox_irq
`default_nettype wire

// [prox_irq_sva.sv]
// Checker for the proximity mode and threshold interrupt block.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module prox_irq_sva #(
    parameter int MEAS_CYC = 4
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Measurement status
    input wire logic o_ready,
    input wire logic o_meas_start,
    input wire logic o_meas_valid,
    input wire logic [15:0] o_proximity_measurement,
    // Interrupt state
    input wire logic o_int_status,
    input wire logic o_far_to_near_report,
    input wire logic o_near_to_far_report,
    // Settings
    input wire logic [7:0] o_proximity_control_register,
    input wire logic [7:0] o_int_cfg,
    input wire logic [15:0] o_upper_limit_value,
    input wire logic [15:0] o_lower_limit_value,
    // Pin
    input wire logic o_int_pin,
    input wire logic o_int_oe_b
);
    // ==========================================================
    // Checks, all on the one clock
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // Logic type needs both selector bits
    wire logic lg = o_proximity_control_register[2] & o_int_cfg[1];
    property p_start;
        o_meas_start |-> $past(o_proximity_control_register[1]);
    endproperty
    a_start: assert property (p_start) else $error("start in stand-by");
    property p_swrst;
        !o_ready |-> !o_meas_start;
    endproperty
    a_swrst: assert property (p_swrst) else $error("start in start-up");
    // A soft reset aborts a measurement and clears active, so that case is excused
    property p_lat;
        o_meas_start |->
            ##MEAS_CYC (o_meas_valid || !o_proximity_control_register[1]);
    endproperty
    a_lat: assert property (p_lat) else $error("result late");
    property p_fresh;
        $rose(o_int_status) |-> $past(o_meas_valid, 2);
    endproperty
    a_fresh: assert property (p_fresh) else $error("stale trigger");
    property p_range;
        $rose(o_int_status) |-> o_proximity_measurement > o_upper_limit_value
            || o_proximity_measurement < o_lower_limit_value;
    endproperty
    a_range: assert property (p_range) else $error("in-range trigger");
    property p_pin;
        !o_int_oe_b |-> o_int_pin == (o_int_status ~^ o_int_cfg[3]);
    endproperty
    a_pin: assert property (p_pin) else $error("pin level");
    property p_oe;
        o_int_oe_b == (o_int_cfg[2:1] == 2'h0);
    endproperty
    a_oe: assert property (p_oe) else $error("pin enable");
    property p_win;
        !lg && !$past(lg) |-> !o_far_to_near_report && !o_near_to_far_report;
    endproperty
    a_win: assert property (p_win) else $error("report in window");
    property p_ftn;
        $rose(o_far_to_near_report) |->
            o_proximity_measurement > o_upper_limit_value;
    endproperty
    a_ftn: assert property (p_ftn) else $error("far-to-near cause");
endmodule // prox_irq_sva
bind prox_irq prox_irq_sva #(.MEAS_CYC(MEAS_CYC)) u_sva (
    .i_clk, .i_rst_b, .o_ready, .o_meas_start, .o_meas_valid,
    .o_proximity_measurement, .o_int_status, .o_far_to_near_report,
    .o_near_to_far_report, .o_proximity_control_register, .o_int_cfg,
    .o_upper_limit_value, .o_lower_limit_value, .o_int_pin, .o_int_oe_b
);
`default_nettype wire

// [prox_host.sv]
// Host side model: register writes, interrupt clear and front-end data.
// Assumes writes are taken at a rising edge with the strobe high.
`timescale 1ns/1ps
`default_nettype none
`include "prox_irq_defines.vh"
module prox_host (
    // Clock
    input wire logic i_clk,
    // Register writes
    output logic o_wr,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata,
    // Clear and data
    output logic o_int_clr,
    output logic [15:0] o_meas_data
);
    // ==========================================================
    // Idle values at time zero
    initial
    begin
        o_wr = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
        o_int_clr = 1'b0;
        o_meas_data = 16'h0000;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
        // Scramble the idle bus so a stale value is never reused
        o_wdata <= ~d;
    endtask
    task automatic set_logic;
        wr(`OFS_PROX_CTRL, 8'h06);
        wr(`OFS_INT_CFG, 8'h42);
    endtask
    task automatic clr;
        @(posedge i_clk);
        o_int_clr <= 1'b1;
        @(posedge i_clk);
        o_int_clr <= 1'b0;
    endtask
    task automatic set_data(input logic [15:0] d);
        @(posedge i_clk);
        o_meas_data <= d;
    endtask
endmodule // prox_host
`default_nettype wire

// [proximity_mode_and_threshold_irq_tb.sv]
// Self-checking bench for the proximity mode and interrupt block.
// Assumes the host model drives every input except clock and reset.
`timescale 1ns/1ps
`default_nettype none
`include "prox_irq_defines.vh"
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
    failures++; $display("wrong value %s exp %0h got %0h", n, e, a); end end
module proximity_mode_and_threshold_irq_tb;
    logic i_clk;
    logic i_rst_b;
    wire logic wr, clr;
    wire logic [7:0] addr, wdata;
    wire logic [15:0] meas;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;
    int k;
    // ==========================================================
    // Short measurement keeps the run brief
    prox_irq #(.MEAS_CYC(4)) uut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_wr(wr), .i_addr(addr),
        .i_wdata(wdata), .i_int_clr(clr), .i_meas_data(meas),
        .o_active(), .o_ready(), .o_meas_start(), .o_meas_valid(),
        .o_proximity_measurement(), .o_int_status(),
        .o_far_to_near_report(), .o_near_to_far_report(),
        .o_proximity_control_register(), .o_int_cfg(), .o_persist(),
        .o_upper_limit_value(), .o_lower_limit_value(),
        .o_int_pin(), .o_int_oe_b()
    );
    prox_host host (.i_clk(i_clk), .o_wr(wr), .o_addr(addr),
        .o_wdata(wdata), .o_int_clr(clr), .o_meas_data(meas));
    initial
    begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    // Hang guard, far above the few hundred cycles needed
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            complete_run;
        end
    end
    task automatic complete_run;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wait_int;
        for (k = 0; k < 100 && uut.o_int_status !== 1'b1; k++)
            @(posedge i_clk);
        #1;
    endtask
    task automatic t_reset;
        `CHK("cfg", 8'h40, uut.o_int_cfg)
        `CHK("upper", 16'hFFFF, uut.o_upper_limit_value)
        `CHK("lower", 16'h0000, uut.o_lower_limit_value)
        `CHK("oe_b", 1'b1, uut.o_int_oe_b)
        repeat (40) @(posedge i_clk);
        #1;
        `CHK("ready", 1'b1, uut.o_ready)
        `CHK("active", 1'b0, uut.o_active)
        $display("t_reset done");
    endtask
    task automatic t_window;
        host.set_data(16'h0300);
        host.wr(`OFS_LOWER_LSB, 8'h10);
        host.wr(`OFS_UPPER_LSB, 8'h00);
        host.wr(`OFS_UPPER_MSB, 8'h02);
        host.wr(`OFS_INT_CFG, 8'h42);
        #1;
        `CHK("upper", 16'h0200, uut.o_upper_limit_value)
        `CHK("status", 1'b0, uut.o_int_status)
        host.wr(`OFS_PROX_CTRL, 8'h02);
        wait_int;
        `CHK("status", 1'b1, uut.o_int_status)
        `CHK("pin", 1'b0, uut.o_int_pin)
        `CHK("ftn", 1'b0, uut.o_far_to_near_report)
        `CHK("meas", 16'h0300, uut.o_proximity_measurement)
        host.wr(`OFS_INT_CFG, 8'h4A);
        #1;
        `CHK("pin", 1'b1, uut.o_int_pin)
        host.wr(`OFS_INT_CFG, 8'h40);
        #1;
        `CHK("oe_b", 1'b1, uut.o_int_oe_b)
        $display("t_window done");
    endtask
    // Old result lies above the new upper limit once measuring stops
    task automatic t_stale;
        host.wr(`OFS_PROX_CTRL, 8'h00);
        // Triggers stay armed, so a compare on old data would show
        host.wr(`OFS_INT_CFG, 8'h42);
        repeat (20) @(posedge i_clk);
        host.clr;
        host.wr(`OFS_UPPER_MSB, 8'h00);
        host.wr(8'h90, 8'hFF);
        repeat (40) @(posedge i_clk);
        #1;
        `CHK("status", 1'b0, uut.o_int_status)
        `CHK("active", 1'b0, uut.o_active)
        `CHK("persist", 8'h00, uut.o_persist)
        $display("t_stale done");
    endtask
    task automatic t_swrst;
        host.wr(`OFS_PROX_CTRL, 8'h01);
        // Ready is registered, so it drops one edge after the defaults
        repeat (2) @(posedge i_clk);
        #1;
        `CHK("ready", 1'b0, uut.o_ready)
        `CHK("ctrl", 8'h00, uut.o_proximity_control_register)
        `CHK("cfg", 8'h40, uut.o_int_cfg)
        `CHK("upper", 16'hFFFF, uut.o_upper_limit_value)
        repeat (30) @(posedge i_clk);
        #1;
        `CHK("ready", 1'b1, uut.o_ready)
        $display("t_swrst done");
    endtask
    task automatic t_persist;
        n = 0;
        host.set_data(16'h0005);
        host.wr(`OFS_LOWER_LSB, 8'h10);
        host.wr(`OFS_PERSIST, 8'h30);
        host.wr(`OFS_INT_CFG, 8'h42);
        host.wr(`OFS_PROX_CTRL, 8'h02);
        @(posedge i_clk);
        #1;
        `CHK("start", 1'b1, uut.o_meas_start)
        @(posedge i_clk);
        #1;
        `CHK("active", 1'b1, uut.o_active)
        for (k = 0; k < 200 && uut.o_int_status !== 1'b1; k++)
        begin
            @(posedge i_clk);
            #1;
            if (uut.o_meas_valid === 1'b1)
                n++;
        end
        `CHK("valids", 3, n)
        $display("t_persist done");
    endtask
    task automatic t_logic;
        host.wr(`OFS_PERSIST, 8'h00);
        host.wr(`OFS_UPPER_MSB, 8'h02);
        host.set_logic;
        host.clr;
        host.set_data(16'h0300);
        repeat (30) @(posedge i_clk);
        #1;
        `CHK("ftn", 1'b1, uut.o_far_to_near_report)
        `CHK("ntf", 1'b0, uut.o_near_to_far_report)
        host.set_data(16'h0005);
        repeat (30) @(posedge i_clk);
        #1;
        `CHK("ntf", 1'b1, uut.o_near_to_far_report)
        `CHK("status", 1'b1, uut.o_int_status)
        $display("t_logic done");
    endtask
    initial
    begin
        i_rst_b = 1'b0;
        repeat (12) @(posedge i_clk);
        i_rst_b <= 1'b1;
        #1;
        t_reset;
        t_window;
        t_stale;
        t_swrst;
        t_persist;
        t_logic;
        complete_run;
    end
endmodule // proximity_mode_and_threshold_irq_tb
`default_nettype wire
